// ### tlic_core.sv
// processor-side end: register access and interrupt acceptance
`timescale 1ns/1ns
`default_nettype none
module tlic_core
  import tlic_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  rst,
  input  wire logic  ce,
  tlic_if.core       bus,
  input  wire logic  cmd_wr,
  input  wire logic  cmd_rd,
  input  wire logic [7:0] cmd_addr,
  input  wire logic [7:0] cmd_wdata,
  input  wire logic  cmd_ret,
  output logic [7:0] cmd_rdata,
  output logic       in_handler,
  output logic [7:0] handler_vector
);
  logic       wr_reg, wr_next, rd_reg, rd_next, ack_reg, ack_next;
  logic       ret_reg, ret_next, inh_reg, inh_next;
  logic [7:0] addr_reg, addr_next, wd_reg, wd_next;
  logic [7:0] rdv_reg, rdv_next, hv_reg, hv_next;
  logic       rdp_reg, rdp_next;
  logic [1:0] dep_reg, dep_next;

  always_comb begin
    wr_next   = cmd_wr;
    rd_next   = cmd_rd;
    addr_next = cmd_addr;
    wd_next   = cmd_wdata;
    ret_next  = cmd_ret && inh_reg;
    // accept a request at most every other cycle; ack clears it on the next edge unless irq_ret is high in the same cycle
    ack_next  = bus.irq_req && !ack_reg;
    dep_next  = dep_reg;
    hv_next   = hv_reg;
    // count nesting, so returning from a preempting handler leaves the
    // preempted one marked as running and its own return still passes
    if (ack_reg) begin
      dep_next = dep_reg + 2'd1;
      hv_next  = bus.irq_vector;
    end else if (ret_reg) begin
      dep_next = dep_reg - 2'd1;
    end
    inh_next  = dep_next != 2'b00;
    // read data stands one edge after the strobe, so capture it then
    rdp_next  = rd_reg;
    rdv_next  = rdp_reg ? bus.sfr_rdata : rdv_reg;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_reg   <= 1'b0;
      rd_reg   <= 1'b0;
      addr_reg <= 8'h00;
      wd_reg   <= 8'h00;
      ret_reg  <= 1'b0;
      ack_reg  <= 1'b0;
      inh_reg  <= 1'b0;
      hv_reg   <= 8'h00;
      rdv_reg  <= 8'h00;
      rdp_reg  <= 1'b0;
      dep_reg  <= 2'b00;
    end else if (ce) begin
      wr_reg   <= wr_next;
      rd_reg   <= rd_next;
      addr_reg <= addr_next;
      wd_reg   <= wd_next;
      ret_reg  <= ret_next;
      ack_reg  <= ack_next;
      inh_reg  <= inh_next;
      hv_reg   <= hv_next;
      rdv_reg  <= rdv_next;
      rdp_reg  <= rdp_next;
      dep_reg  <= dep_next;
    end
  end

  assign bus.sfr_wr    = wr_reg;
  assign bus.sfr_rd    = rd_reg;
  assign bus.sfr_addr  = addr_reg;
  assign bus.sfr_wdata = wd_reg;
  assign bus.irq_ack   = ack_reg;
  assign bus.irq_ret   = ret_reg;
  assign cmd_rdata      = rdv_reg;
  assign in_handler     = inh_reg;
  assign handler_vector = hv_reg;
endmodule
`default_nettype wire

// ### tlic_ctrl.sv
// interrupt controller: flags, enables, priorities, arbitration
`timescale 1ns/1ns
`default_nettype none
module tlic_ctrl
  import tlic_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  rst,
  input  wire logic  ce,
  tlic_if.dev        bus,
  input  wire logic  ext_line_0_n,
  input  wire logic  ext_line_1_n,
  input  wire logic  ext_line_2_n,
  input  wire logic  ext3_set,
  input  wire logic  ext3_clr,
  input  wire logic  ext4_set,
  input  wire logic  ext4_clr,
  input  wire logic  radio_set,
  input  wire logic  key_wake_set,
  input  wire logic  timer0_ovf,
  input  wire logic  timer1_ovf,
  input  wire logic  timer2_req,
  input  wire logic  uart_rx_set,
  input  wire logic  uart_tx_set,
  input  wire logic  wdog_req,
  input  wire logic  i2c_master_set,
  input  wire logic  i2c_slave_set,
  input  wire logic  spi_set,
  output logic [7:0] timer_ext_control,
  output logic [7:0] serial_control
);
  logic [7:0] tmx_reg, tmx_next, ser_reg, ser_next;
  logic [7:0] eflg_reg, eflg_next, ien_reg, ien_next;
  logic [7:0] ipri_reg, ipri_next, eien_reg, eien_next;
  logic [7:0] eipr_reg, eipr_next, rdata_reg, rdata_next;
  logic       l0_reg, l1_reg;
  logic       req_reg, req_next;
  logic [7:0] vec_reg, vec_next;
  logic [3:0] num_reg, num_next;
  logic [3:0] act_src_reg, act_src_next;
  tlic_level_e lvl_reg, lvl_next;
  logic [1:0] stk_reg, stk_next;
  logic [NSRC-1:0] pend, en, hi;
  logic [3:0] win_hi, win_lo;
  logic       any_hi, any_lo;
  logic       wr_tmx, wr_ser, wr_eflg;

  assign wr_tmx  = bus.sfr_wr && bus.sfr_addr == ADDR_TMX_R;
  assign wr_ser  = bus.sfr_wr && bus.sfr_addr == ADDR_SER_R;
  assign wr_eflg = bus.sfr_wr && bus.sfr_addr == ADDR_EFLG_R;

  // slot index = natural priority - 1; slots 6, 8, 9 are reserved
  always_comb begin
    pend = '0;
    en   = '0;
    hi   = '0;
    pend[0]  = tmx_reg[1];
    pend[1]  = tmx_reg[5];
    pend[2]  = tmx_reg[3];
    pend[3]  = tmx_reg[7];
    pend[4]  = ser_reg[0] | ser_reg[1];
    pend[5]  = timer2_req;
    pend[7]  = eflg_reg[0] | eflg_reg[1] | eflg_reg[2];
    pend[10] = eflg_reg[3];
    pend[11] = eflg_reg[4];
    pend[12] = wdog_req;
    pend[13] = eflg_reg[6];
    pend[14] = eflg_reg[7];
    // primary bit order already matches slot order
    en[5:0]  = ien_reg[5:0];
    hi[5:0]  = ipri_reg[5:0];
    // lines 2-4 share slot 7; the enable of each gates its own flag
    en[7]    = |(eflg_reg[2:0] & eien_reg[2:0]);
    hi[7]    = |(eflg_reg[2:0] & eipr_reg[2:0]);
    en[14:10] = {eien_reg[7:3]};
    hi[14:10] = {eipr_reg[7:3]};
  end

  // lowest slot number wins within a level
  always_comb begin
    win_hi = NO_SRC;
    win_lo = NO_SRC;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (pend[i] && en[i] && ien_reg[GLOBAL_BIT]) begin
        if (hi[i]) win_hi = 4'(i);
        else       win_lo = 4'(i);
      end
    end
    any_hi = win_hi != NO_SRC;
    any_lo = win_lo != NO_SRC;
  end

  always_comb begin
    tmx_next  = tmx_reg;
    ser_next  = ser_reg;
    eflg_next = eflg_reg;
    ien_next  = ien_reg;
    ipri_next = ipri_reg;
    eien_next = eien_reg;
    eipr_next = eipr_reg;
    if (bus.sfr_wr) begin
      case (bus.sfr_addr)
        ADDR_IEN_R:  ien_next  = bus.sfr_wdata & 8'hbf;
        ADDR_IPRI_R: ipri_next = bus.sfr_wdata & 8'h3f;
        ADDR_EIEN_R: eien_next = bus.sfr_wdata;
        ADDR_EIPR_R: eipr_next = bus.sfr_wdata;
        default: ;
      endcase
    end
    if (wr_tmx) tmx_next = bus.sfr_wdata;
    if (wr_ser) ser_next = bus.sfr_wdata;
    // extended flags: writes may only clear; bits 2:1 clear on a written zero, bits 3/4/6/7 on their own one-hot code
    if (wr_eflg) begin
      if (bus.sfr_wdata == RADIO_CLR)  eflg_next[3] = 1'b0;
      if (bus.sfr_wdata == KEY_CLR)    eflg_next[4] = 1'b0;
      if (bus.sfr_wdata == I2CM_CLR)   eflg_next[6] = 1'b0;
      if (bus.sfr_wdata == SHARED_CLR) eflg_next[7] = 1'b0;
      eflg_next[2:1] = eflg_reg[2:1] & bus.sfr_wdata[2:1];
    end
    // acknowledge clears the vectored flag (edge/timer only)
    if (bus.irq_ack) begin
      case (num_reg)
        4'h0: tmx_next[1] = 1'b0;
        4'h1: tmx_next[5] = 1'b0;
        4'h2: tmx_next[3] = 1'b0;
        4'h3: tmx_next[7] = 1'b0;
        default: ;
      endcase
    end
    // hardware sets win over clears in the same cycle
    if (timer0_ovf) tmx_next[5] = 1'b1;
    if (timer1_ovf) tmx_next[7] = 1'b1;
    if (uart_rx_set) ser_next[0] = 1'b1;
    if (uart_tx_set) ser_next[1] = 1'b1;
    // low level or falling edge on lines 0/1
    if (!tmx_reg[0]) tmx_next[1] = !ext_line_0_n;
    else if (l0_reg && !ext_line_0_n) tmx_next[1] = 1'b1;
    if (!tmx_reg[2]) tmx_next[3] = !ext_line_1_n;
    else if (l1_reg && !ext_line_1_n) tmx_next[3] = 1'b1;
    eflg_next[0] = !ext_line_2_n;
    if (ext3_clr) eflg_next[1] = 1'b0;
    if (ext4_clr) eflg_next[2] = 1'b0;
    if (ext3_set) eflg_next[1] = 1'b1;
    if (ext4_set) eflg_next[2] = 1'b1;
    if (radio_set) eflg_next[3] = 1'b1;
    if (key_wake_set) eflg_next[4] = 1'b1;
    if (i2c_master_set) eflg_next[6] = 1'b1;
    if (i2c_slave_set || spi_set) eflg_next[7] = 1'b1;
    eflg_next[5] = 1'b0;
  end

  // nesting: low handler may be preempted by high, never the reverse
  always_comb begin
    lvl_next     = lvl_reg;
    stk_next     = stk_reg;
    act_src_next = act_src_reg;
    // a raised request stands until the core acknowledges it
    req_next     = req_reg;
    num_next     = num_reg;
    vec_next     = vec_reg;
    if (bus.irq_ret) begin
      stk_next = {1'b0, stk_reg[1]};
      lvl_next = stk_reg[1] ? TLIC_LOW : TLIC_IDLE;
    end else if (bus.irq_ack) begin
      stk_next     = {stk_reg[0], 1'b1};
      req_next     = 1'b0;
      lvl_next     = hi[num_reg] ? TLIC_HIGH : TLIC_LOW;
      act_src_next = num_reg;
    end else if (!req_reg) begin
      if (any_hi && lvl_reg != TLIC_HIGH) begin
        req_next = 1'b1;
        num_next = win_hi;
      end else if (any_lo && lvl_reg == TLIC_IDLE) begin
        req_next = 1'b1;
        num_next = win_lo;
      end
      vec_next = VEC_BASE + 8'(VEC_STEP) * {4'h0, num_next};
    end
  end

  always_comb begin
    case (bus.sfr_addr)
      ADDR_TMX_R:  rdata_next = tmx_reg;
      ADDR_EFLG_R: rdata_next = eflg_reg;
      ADDR_SER_R:  rdata_next = ser_reg;
      ADDR_IEN_R:  rdata_next = ien_reg;
      ADDR_IPRI_R: rdata_next = ipri_reg;
      ADDR_EIEN_R: rdata_next = eien_reg;
      ADDR_EIPR_R: rdata_next = eipr_reg;
      default:     rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tmx_reg     <= RESET_VAL;
      ser_reg     <= RESET_VAL;
      eflg_reg    <= RESET_VAL;
      ien_reg     <= RESET_VAL;
      ipri_reg    <= RESET_VAL;
      eien_reg    <= RESET_VAL;
      eipr_reg    <= RESET_VAL;
      rdata_reg   <= RESET_VAL;
      l0_reg      <= 1'b1;
      l1_reg      <= 1'b1;
      req_reg     <= 1'b0;
      vec_reg     <= RESET_VAL;
      num_reg     <= 4'h0;
      act_src_reg <= 4'h0;
      lvl_reg     <= TLIC_IDLE;
      stk_reg     <= 2'b00;
    end else if (ce) begin
      tmx_reg     <= tmx_next;
      ser_reg     <= ser_next;
      eflg_reg    <= eflg_next;
      ien_reg     <= ien_next;
      ipri_reg    <= ipri_next;
      eien_reg    <= eien_next;
      eipr_reg    <= eipr_next;
      rdata_reg   <= rdata_next;
      l0_reg      <= ext_line_0_n;
      l1_reg      <= ext_line_1_n;
      req_reg     <= req_next;
      vec_reg     <= vec_next;
      num_reg     <= num_next;
      act_src_reg <= act_src_next;
      lvl_reg     <= lvl_next;
      stk_reg     <= stk_next;
    end
  end

  assign bus.sfr_rdata      = rdata_reg;
  assign bus.irq_req        = req_reg;
  assign bus.irq_vector     = vec_reg;
  assign bus.irq_num        = num_reg;
  assign timer_ext_control  = tmx_reg;
  assign serial_control     = ser_reg;
endmodule
`default_nettype wire

// ### tlic_if.sv
// core-side connection between controller and processor model
`timescale 1ns/1ns
`default_nettype none
interface tlic_if;
  logic       sfr_wr;
  logic       sfr_rd;
  logic [7:0] sfr_addr;
  logic [7:0] sfr_wdata;
  logic [7:0] sfr_rdata;
  logic       irq_req;
  logic [7:0] irq_vector;
  logic [3:0] irq_num;
  logic       irq_ack;
  logic       irq_ret;
  modport dev  (input sfr_wr, sfr_rd, sfr_addr, sfr_wdata, irq_ack,
                irq_ret, output sfr_rdata, irq_req, irq_vector, irq_num);
  modport core (output sfr_wr, sfr_rd, sfr_addr, sfr_wdata, irq_ack,
                irq_ret, input sfr_rdata, irq_req, irq_vector, irq_num);
endinterface
`default_nettype wire

// ### tlic_pkg.sv
// constants for the two-level interrupt controller
// Behaviour
// - global enable bit 7 gates all interrupts
// - primary enable bits gate each primary source
// - software flag writes act like hardware
// - level-mode lines 0/1 follow pin, no set
// - extended line, radio, key flags not software-set
// - primary priority bits mirror enable order
// - select bit zero level, one edge
// - line and timer flags clear on vectoring
// - uart rx bit0, tx bit1, either requests
// - extended enable bits gate extended sources
// - extended priority mirrors extended enable layout
// - line 2 flag copies pin every clock
// - lines 2-4 sources clear their own flags
// - software clears radio flag writing 0x08
// - software clears key flag writing 0x10
// - i2c master flag cleared by write only
// - shared slave/spi flag cleared, handler checks both
// - extended flag register bit layout fixed
// - all registers reset to zero
// - requests sampled every rising clock edge
// - vectors assigned by natural priority order
// - two priority levels selected per source
// - external pins active low or falling
package tlic_pkg;
  localparam logic [7:0] ADDR_TMX_R  = 8'h88;
  localparam logic [7:0] ADDR_EFLG_R = 8'h91;
  localparam logic [7:0] ADDR_SER_R  = 8'h98;
  localparam logic [7:0] ADDR_IEN_R  = 8'ha8;
  localparam logic [7:0] ADDR_IPRI_R = 8'hb8;
  localparam logic [7:0] ADDR_EIEN_R = 8'he8;
  localparam logic [7:0] ADDR_EIPR_R = 8'hf8;
  localparam logic [7:0] RESET_VAL   = 8'h00;
  localparam int         GLOBAL_BIT  = 7;
  localparam int         NSRC        = 15;
  localparam logic [3:0] NO_SRC      = 4'hf;
  localparam logic [7:0] VEC_BASE    = 8'h03;
  localparam int         VEC_STEP    = 8;
  localparam logic [7:0] RADIO_CLR   = 8'h08;
  localparam logic [7:0] KEY_CLR     = 8'h10;
  localparam logic [7:0] I2CM_CLR    = 8'h40;
  localparam logic [7:0] SHARED_CLR  = 8'h80;
  typedef enum logic [1:0] {
    TLIC_IDLE = 2'b00,
    TLIC_LOW  = 2'b01,
    TLIC_HIGH = 2'b11
  } tlic_level_e;
endpackage

// ### tlic_properties.sv
// concurrent checks on the controller to core link
`timescale 1ns/1ns
`default_nettype none
module tlic_properties
  import tlic_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       sfr_wr,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic       irq_req,
  input wire logic [7:0] irq_vector,
  input wire logic [3:0] irq_num,
  input wire logic       irq_ack,
  input wire logic       irq_ret
);
  // shadow of the enable register, built only from bus writes
  logic [7:0] ien_reg;
  logic [7:0] ien_next;
  always_comb begin
    ien_next = ien_reg;
    if (sfr_wr && sfr_addr == ADDR_IEN_R)
      ien_next = sfr_wdata & 8'hbf; // bit 6 has no storage
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      ien_reg <= RESET_VAL;
    else
      ien_reg <= ien_next;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_grant;
    irq_req && irq_ack;
  endsequence
  sequence s_ien_read;
    sfr_rd && sfr_addr == ADDR_IEN_R;
  endsequence
  a_reset_idle: assert property (disable iff (1'b0)
    rst |-> !irq_req && irq_vector == 8'h00 && sfr_rdata == 8'h00)
    else $error("outputs not idle in reset");
  a_global_gate: assert property (
    $rose(irq_req) |-> $past(ien_reg[GLOBAL_BIT]))
    else $error("request raised with global enable off");
  a_vector_slot: assert property (
    irq_req |-> irq_vector == 8'(int'(VEC_BASE) + VEC_STEP * int'(irq_num)))
    else $error("vector does not match slot");
  a_slot_valid: assert property (
    irq_req |-> irq_num inside {[4'h0:4'h5], 4'h7, [4'ha:4'he]})
    else $error("request from an unused slot");
  a_req_stands: assert property (
    irq_req && !irq_ack |=> irq_req)
    else $error("request dropped before acknowledge");
  a_grant_clears: assert property (s_grant |=> !irq_req)
    else $error("request still high after acknowledge");
  a_ack_follows: assert property (
    irq_ack |-> $past(irq_req) ##1 !irq_ack)
    else $error("acknowledge without request or too long");
  a_ien_readback: assert property (
    s_ien_read |=> sfr_rdata == ien_reg)
    else $error("enable register reads back wrong");
endmodule
`default_nettype wire

// ### two_level_interrupt_controller_test.sv
// self-checking bench: controller and core joined by the link
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin \
  n_fail++; $display("wrong value %s exp %0h got %0h", n, e, g); end end
module two_level_interrupt_controller_test
  import tlic_pkg::*;
;
  logic        clk, rst, cmd_wr, cmd_rd, cmd_ret, in_handler;
  logic        ext0_n, ext1_n, ext2_n;
  logic [7:0]  cmd_addr, cmd_wdata, cmd_rdata, handler_vector;
  logic [7:0]  tmx_q, ser_q;
  logic [14:0] src;
  int          n_fail, n_checks;
  logic [7:0] ra [8] = '{8'h88, 8'h91, 8'h98, 8'ha8, 8'hb8, 8'he8, 8'hf8,
                         8'h90};
  logic [7:0] wv [4] = '{8'hbf, 8'h3f, 8'hff, 8'hff};
  logic [7:0] fv [7] = '{8'h08, 8'h10, 8'h40, 8'h80, 8'h80, 8'h02, 8'h04};
  logic [7:0] pe [10] = '{8'h82, 8'h88, 8'ha0, 8'h90, 8'h80, 8'h80, 8'h80,
                          8'h80, 8'h80, 8'h80};
  logic [7:0] ee [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h20, 8'h08, 8'h10,
                          8'h40, 8'h80, 8'h02};
  logic [7:0] vc [10] = '{8'h0b, 8'h1b, 8'h2b, 8'h23, 8'h63, 8'h53, 8'h5b,
                          8'h6b, 8'h73, 8'h3b};
  logic [7:0] ca [10] = '{8'h88, 8'h88, 8'h88, 8'h98, 8'h88, 8'h91, 8'h91,
                          8'h91, 8'h91, 8'h91};
  logic [7:0] cv [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h08, 8'h10,
                          8'h40, 8'h80, 8'h00};
  int         sb [10] = '{0, 1, 2, 4, 5, 6, 7, 8, 10, 11};
  tlic_if bus ();
  tlic_ctrl tlic_ctrl_inst (.clk(clk), .rst(rst), .ce(1'b1), .bus(bus),
    .ext_line_0_n(ext0_n), .ext_line_1_n(ext1_n), .ext_line_2_n(ext2_n),
    .timer0_ovf(src[0]), .timer1_ovf(src[1]), .timer2_req(src[2]),
    .uart_rx_set(src[3]), .uart_tx_set(src[4]), .wdog_req(src[5]),
    .radio_set(src[6]), .key_wake_set(src[7]), .i2c_master_set(src[8]),
    .i2c_slave_set(src[9]), .spi_set(src[10]), .ext3_set(src[11]),
    .ext4_set(src[12]), .ext3_clr(src[13]), .ext4_clr(src[14]),
    .timer_ext_control(tmx_q), .serial_control(ser_q));
  tlic_core tlic_core_inst (.clk(clk), .rst(rst), .ce(1'b1), .bus(bus),
    .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .cmd_ret(cmd_ret), .cmd_rdata(cmd_rdata),
    .in_handler(in_handler), .handler_vector(handler_vector));
  tlic_properties tlic_properties_chk (.clk(clk), .rst(rst),
    .sfr_wr(bus.sfr_wr), .sfr_rd(bus.sfr_rd), .sfr_addr(bus.sfr_addr),
    .sfr_wdata(bus.sfr_wdata), .sfr_rdata(bus.sfr_rdata),
    .irq_req(bus.irq_req), .irq_vector(bus.irq_vector),
    .irq_num(bus.irq_num), .irq_ack(bus.irq_ack), .irq_ret(bus.irq_ret));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    cmd_wr = 1'b1;
    cmd_addr = a;
    cmd_wdata = d;
    @(negedge clk);
    cmd_wr = 1'b0;
  endtask
  // read data lands two edges after the command is taken
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    cmd_rd = 1'b1;
    cmd_addr = a;
    @(negedge clk);
    cmd_rd = 1'b0;
    repeat (3) @(negedge clk);
    `CHK("rdata", e, cmd_rdata)
  endtask
  task automatic fire(input logic [14:0] m);
    @(negedge clk);
    src = m;
    @(negedge clk);
    src = '0;
  endtask
  task automatic ret();
    @(negedge clk);
    cmd_ret = 1'b1;
    @(negedge clk);
    cmd_ret = 1'b0;
  endtask
  // bounded wait for the acknowledge, then the handler must be entered
  task automatic take(input logic [7:0] v);
    int i;
    i = 0;
    while (bus.irq_ack !== 1'b1 && i < 40) begin
      @(negedge clk);
      i++;
    end
    @(negedge clk);
    `CHK("handler", {1'b1, v}, {in_handler, handler_vector})
  endtask
  initial begin
    repeat (4000) @(posedge clk);
    n_fail++;
    give_verdict();
  end
  initial begin
    {rst, cmd_wr, cmd_rd, cmd_ret, cmd_addr, cmd_wdata, src} = '0;
    rst = 1'b1;
    {ext0_n, ext1_n, ext2_n} = 3'b111;
    n_fail = 0;
    n_checks = 0;
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    for (int i = 0; i < 8; i++) rd(ra[i], 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(ra[i + 3], wv[i]);
      rd(ra[i + 3], wv[i]);
      wr(ra[i + 3], 8'h00);
    end
    wr(ADDR_EFLG_R, 8'hff);
    rd(ADDR_EFLG_R, 8'h00);
    for (int i = 0; i < 7; i++) begin
      fire(15'(1) << (i + 6));
      rd(ADDR_EFLG_R, fv[i]);
      if (i < 5) wr(ADDR_EFLG_R, fv[i]);
      else fire(15'(1) << (i + 8));
      rd(ADDR_EFLG_R, 8'h00);
    end
    ext2_n = 1'b0;
    rd(ADDR_EFLG_R, 8'h01);
    ext2_n = 1'b1;
    rd(ADDR_EFLG_R, 8'h00);
    ext0_n = 1'b0;
    rd(ADDR_TMX_R, 8'h02);
    ext0_n = 1'b1;
    wr(ADDR_TMX_R, 8'h02);
    rd(ADDR_TMX_R, 8'h00);
    wr(ADDR_TMX_R, 8'h05);
    ext1_n = 1'b0;
    repeat (2) @(negedge clk);
    ext1_n = 1'b1;
    rd(ADDR_TMX_R, 8'h0d);
    `CHK("timer_ext", 8'h0d, tmx_q)
    wr(ADDR_TMX_R, 8'h05);
    rd(ADDR_TMX_R, 8'h05);
    fire(15'h0008);
    @(negedge clk);
    `CHK("serial", 8'h01, ser_q)
    wr(ADDR_SER_R, 8'h00);
    wr(ADDR_IEN_R, 8'h81);
    ext0_n = 1'b0;
    take(8'h03);
    ext0_n = 1'b1;
    rd(ADDR_TMX_R, 8'h05);
    ret();
    wr(ADDR_TMX_R, 8'h00);
    wr(ADDR_IEN_R, 8'h02);
    fire(15'h0001);
    repeat (6) @(negedge clk);
    `CHK("in_handler", 1'b0, in_handler)
    rd(ADDR_TMX_R, 8'h20);
    wr(ADDR_TMX_R, 8'h00);
    rd(ADDR_TMX_R, 8'h00);
    for (int i = 0; i < 10; i++) begin
      wr(ADDR_EIEN_R, ee[i]);
      wr(ADDR_IEN_R, pe[i]);
      fire(15'(1) << sb[i]);
      take(vc[i]);
      wr(ca[i], cv[i]);
      wr(ADDR_IEN_R, 8'h00);
      ret();
    end
    wr(ADDR_EIEN_R, 8'h00);
    wr(ADDR_IEN_R, 8'h8a);
    fire(15'h0003);
    take(8'h0b);
    ret();
    take(8'h1b);
    ret();
    wr(ADDR_IPRI_R, 8'h08);
    fire(15'h0001);
    take(8'h0b);
    fire(15'h0002);
    take(8'h1b);
    ret();
    repeat (2) @(negedge clk);
    `CHK("in_handler", 1'b1, in_handler)
    ret();
    repeat (2) @(negedge clk);
    `CHK("in_handler", 1'b0, in_handler)
    repeat (4) @(negedge clk);
    give_verdict();
  end
endmodule
`default_nettype wire
